// file: logic/tpm_pin_irq_map.sv
// Behaviour
// R1 - Eleven sources, set by enable, cleared by disable.
// R2 - Overflow, C, trigger, pin flags in both modes.
// R3 - Overrun and capture loads only in capture mode.
// R4 - Compare A and B only in waveform mode.
// R5 - Three pins per channel, owner chosen per pin.
// R6 - Each channel clock gated on its own.
// R7 - Three channels at 0x100 spaced bases.
// R8 - Shared block and test control and mode.
// R9 - Pio enable bits hand pins to plain I/O.
// R10 - Pio disable bits return pins to timer.
// R11 - Pio status shows owners, resets all ones.
// R12 - Output driver enable, disable, status, reset zero.
// R13 - Level set, clear, status and pin levels.
// R14 - Open drain enable, disable, status, reset zero.
// R15 - Clock enable, disable, power status reset zero.
// R16 - Compare registers A, B, C and counter read.
// R17 - Plain I/O wins over timer on a pin.
// R18 - Set drives level one, clear drives zero.
// R19 - Zero bits in strobe registers change nothing.
// R20 - Interrupt when flag set and mask bit one.
// R21 - Reserved offsets: writes ignored, reads zero.
`timescale 1ns/1ps

module tpm_pin_irq_map
  import tpm_pkg::*;
(
  // Clock and reset
  input  wire logic                         ref_clk_in,
  input  wire logic                         nrst_in,
  // APB slave
  input  wire logic                         psel_in,
  input  wire logic                         penable_in,
  input  wire logic                         pwrite_in,
  input  wire logic [AW-1:0]                paddr_in,
  input  wire logic [31:0]                  pwdata_in,
  output logic      [31:0]                  prdata_out,
  output logic                              pready_out,
  output logic                              pslverr_out,
  // Counter logic of each channel
  input  wire tpm_tmr_in_s  [NCH-1:0]       tmr_in,
  output tpm_tmr_out_s      [NCH-1:0]       tmr_out,
  output logic              [NCH-1:0]       irq_out,
  // Shared block and test controls
  output logic                              blk_ctl_stb_out,
  output logic      [31:0]                  blk_ctl_data_out,
  output logic      [31:0]                  blk_mode_out,
  output logic                              tst_ctl_stb_out,
  output logic      [31:0]                  tst_ctl_data_out,
  output logic      [31:0]                  tst_mode_out,
  // Timer pins, index 0 wave B, 1 wave A, 2 external clock
  input  wire logic [NCH-1:0][NPIN-1:0]     pin_in,
  output logic      [NCH-1:0][NPIN-1:0]     pin_out,
  output logic      [NCH-1:0][NPIN-1:0]     pin_oe_out
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [2:0]  pio;
    logic [2:0]  oe;
    logic [2:0]  od;
    logic [2:0]  lvl;
    logic [2:0]  s1;
    logic [2:0]  s2;
    logic [2:0]  prev;
    logic [2:0]  warm;
    logic        clk_on;
    logic [31:0] mode;
    logic [10:0] imr;
    logic [10:0] flags;
    logic [15:0] cc_a;
    logic [15:0] cc_b;
    logic [15:0] cmp_c;
    logic        ctl_stb;
    logic [31:0] ctl_data;
    logic        irq;
    logic [2:0]  pout;
    logic [2:0]  poe;
  } tpm_chan_s;

  typedef struct packed {
    tpm_chan_s [NCH-1:0] ch;
    logic                rdy;
    logic                slverr;
    logic [31:0]         rdata;
    logic [31:0]         bmode;
    logic [31:0]         tmode;
    logic                bctl_stb;
    logic [31:0]         bctl_data;
    logic                tctl_stb;
    logic [31:0]         tctl_data;
  } tpm_state_s;

  tpm_state_s st_r;
  tpm_state_s st_nxt;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic [10:0] avail(input logic wave);
    avail = AVAIL_BOTH | (wave ? AVAIL_WAVE : AVAIL_CAPT);  // [R2] [R3] [R4]
  endfunction

  function automatic logic [2:0] pins_of(input logic [31:0] w);
    pins_of = w[PIN_LSB +: NPIN];
  endfunction

  function automatic logic [31:0] pins_word(input logic [2:0] p);
    pins_word = {13'h0000, p, 16'h0000};
  endfunction

  // ----------------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------------
  logic       acc;
  logic       wr;
  logic       rd_done;
  logic [3:0] ch_idx;
  logic [7:0] ofs;

  // A transfer completes on the second access cycle, when pready is high.
  assign acc     = psel_in & penable_in & st_r.rdy;
  assign wr      = acc & pwrite_in;
  assign rd_done = acc & ~pwrite_in;
  assign ch_idx  = paddr_in[11:8];  // [R7]
  assign ofs     = paddr_in[7:0];

  // ----------------------------------------------------------------------
  // Read multiplexer
  // ----------------------------------------------------------------------
  logic [31:0] rd_mux;

  always_comb begin
    rd_mux = RST_WORD;
    if (ch_idx < 4'(NCH)) begin
      for (int c = 0; c < NCH; c++) begin
        if (ch_idx == 4'(c)) begin
          unique case (ofs)
            OFS_PIO_ST:   rd_mux = pins_word(st_r.ch[c].pio);      // [R11]
            OFS_OE_ST:    rd_mux = pins_word(st_r.ch[c].oe);       // [R12]
            OFS_LVL_ST:   rd_mux = pins_word(st_r.ch[c].lvl);      // [R13]
            OFS_PIN_ST:   rd_mux = pins_word(st_r.ch[c].s2);       // [R13]
            OFS_OD_ST:    rd_mux = pins_word(st_r.ch[c].od);       // [R14]
            OFS_PWR_ST:   rd_mux = {31'h0000_0000, st_r.ch[c].clk_on};  // [R15]
            OFS_MODE:     rd_mux = st_r.ch[c].mode;
            OFS_STATUS:   rd_mux = {21'h00_0000, st_r.ch[c].flags};
            OFS_IRQ_MASK: rd_mux = {21'h00_0000, st_r.ch[c].imr};
            OFS_CNT:      rd_mux = {16'h0000, tmr_in[c].cnt};      // [R16]
            OFS_CC_A:     rd_mux = {16'h0000, st_r.ch[c].cc_a};    // [R16]
            OFS_CC_B:     rd_mux = {16'h0000, st_r.ch[c].cc_b};
            OFS_CMP_C:    rd_mux = {16'h0000, st_r.ch[c].cmp_c};
            default:      rd_mux = RST_WORD;                        // [R21]
          endcase
        end
      end
    end else if (paddr_in == OFS_BLK_MODE) begin
      rd_mux = st_r.bmode;                                          // [R8]
    end else if (paddr_in == OFS_TST_MODE) begin
      rd_mux = st_r.tmode;                                          // [R8]
    end
  end

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    logic        hit;
    logic        wave;
    logic [2:0]  wp;
    logic [2:0]  chg;
    logic [10:0] evt;
    logic [10:0] clr;
    logic [2:0]  own_lvl;
    logic [2:0]  own_drv;
    hit     = 1'b0;
    wave    = 1'b0;
    wp      = pins_of(pwdata_in);
    chg     = 3'h0;
    evt     = RST_IRQ;
    clr     = RST_IRQ;
    own_lvl = 3'h0;
    own_drv = 3'h0;
    st_nxt  = st_r;

    // One wait state keeps every bus output straight from a flip-flop.
    st_nxt.rdy    = psel_in & penable_in & ~st_r.rdy;
    st_nxt.slverr = 1'b0;
    if (psel_in & penable_in & ~st_r.rdy) begin
      st_nxt.rdata = rd_mux;
    end

    st_nxt.bctl_stb = 1'b0;
    st_nxt.tctl_stb = 1'b0;
    if (wr) begin
      unique case (paddr_in)
        OFS_BLK_CTRL: begin
          st_nxt.bctl_stb  = 1'b1;                                  // [R8]
          st_nxt.bctl_data = pwdata_in;
        end
        OFS_BLK_MODE: st_nxt.bmode = pwdata_in;                     // [R8]
        OFS_TST_CTRL: begin
          st_nxt.tctl_stb  = 1'b1;                                  // [R8]
          st_nxt.tctl_data = pwdata_in;
        end
        OFS_TST_MODE: st_nxt.tmode = pwdata_in;                     // [R8]
        default: ;
      endcase
    end

    for (int c = 0; c < NCH; c++) begin
      hit = wr && (ch_idx == 4'(c));
      st_nxt.ch[c].ctl_stb = 1'b0;

      // Pins pass two flip-flops; only the second feeds any logic.
      st_nxt.ch[c].s1   = pin_in[c];
      st_nxt.ch[c].s2   = st_r.ch[c].s1;
      st_nxt.ch[c].prev = st_r.ch[c].s2;
      st_nxt.ch[c].warm = {st_r.ch[c].warm[1:0], 1'b1};
      // The detector stays blind until both compared flops hold real pin levels,
      // so leaving reset never fakes a pin event.
      chg = (st_r.ch[c].s2 ^ st_r.ch[c].prev) & {NPIN{st_r.ch[c].warm[2]}};

      // Only bits written as one act on the strobe registers.
      if (hit) begin
        unique case (ofs)
          OFS_PIO_EN:  st_nxt.ch[c].pio = st_r.ch[c].pio | wp;      // [R9] [R19]
          OFS_PIO_DIS: st_nxt.ch[c].pio = st_r.ch[c].pio & ~wp;     // [R10] [R19]
          OFS_OE_EN:   st_nxt.ch[c].oe  = st_r.ch[c].oe | wp;       // [R12] [R19]
          OFS_OE_DIS:  st_nxt.ch[c].oe  = st_r.ch[c].oe & ~wp;      // [R12] [R19]
          OFS_LVL_SET: st_nxt.ch[c].lvl = st_r.ch[c].lvl | wp;      // [R18] [R19]
          OFS_LVL_CLR: st_nxt.ch[c].lvl = st_r.ch[c].lvl & ~wp;     // [R18] [R19]
          OFS_OD_EN:   st_nxt.ch[c].od  = st_r.ch[c].od | wp;       // [R14] [R19]
          OFS_OD_DIS:  st_nxt.ch[c].od  = st_r.ch[c].od & ~wp;      // [R14] [R19]
          OFS_CLK_EN:  st_nxt.ch[c].clk_on = st_r.ch[c].clk_on | pwdata_in[PWR_BIT]; // [R6]
          OFS_CLK_DIS: st_nxt.ch[c].clk_on = st_r.ch[c].clk_on & ~pwdata_in[PWR_BIT];
          OFS_CTRL: begin
            st_nxt.ch[c].ctl_stb  = 1'b1;
            st_nxt.ch[c].ctl_data = pwdata_in;
          end
          OFS_MODE:    st_nxt.ch[c].mode  = pwdata_in;
          OFS_IRQ_EN:  st_nxt.ch[c].imr   = st_r.ch[c].imr | pwdata_in[NIRQ-1:0];  // [R1]
          OFS_IRQ_DIS: st_nxt.ch[c].imr   = st_r.ch[c].imr & ~pwdata_in[NIRQ-1:0]; // [R1]
          OFS_CC_A:    st_nxt.ch[c].cc_a  = pwdata_in[15:0];        // [R16]
          OFS_CC_B:    st_nxt.ch[c].cc_b  = pwdata_in[15:0];        // [R16]
          OFS_CMP_C:   st_nxt.ch[c].cmp_c = pwdata_in[15:0];        // [R16]
          default: ;                                                // [R21]
        endcase
      end

      // Events outside the current mode never reach the flags.
      wave = st_r.ch[c].mode[MODE_WAVE_BIT];
      evt  = {chg[0], chg[1], chg[2], tmr_in[c].evt} & avail(wave); // [R2] [R3] [R4]
      if (rd_done && (ch_idx == 4'(c)) && (ofs == OFS_STATUS)) begin
        clr = {NIRQ{1'b1}};
      end else begin
        clr = RST_IRQ;
      end
      // A new event in the clearing read's cycle survives the clear.
      st_nxt.ch[c].flags = (st_r.ch[c].flags & ~clr) | evt;         // [R1]
      if (evt[IRQ_LDA]) begin
        st_nxt.ch[c].cc_a = tmr_in[c].cnt;
      end
      if (evt[IRQ_LDB]) begin
        st_nxt.ch[c].cc_b = tmr_in[c].cnt;
      end

      st_nxt.ch[c].irq = |(st_nxt.ch[c].flags & st_nxt.ch[c].imr);  // [R20]

      // Plain I/O owns a pin outright; the timer drives only the rest.
      for (int p = 0; p < NPIN; p++) begin
        own_lvl[p] = st_r.ch[c].pio[p] ? st_r.ch[c].lvl[p] : tmr_in[c].wave_lvl[p]; // [R17]
        own_drv[p] = st_r.ch[c].pio[p] ? st_r.ch[c].oe[p]  : tmr_in[c].wave_drv[p]; // [R5]
      end
      // An open-drain pin only ever pulls low.
      st_nxt.ch[c].pout = own_lvl & ~st_r.ch[c].od;                 // [R14]
      st_nxt.ch[c].poe  = own_drv & (~st_r.ch[c].od | ~own_lvl);    // [R14]
    end
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st_r           <= '0;
      for (int c = 0; c < NCH; c++) begin
        st_r.ch[c].pio <= RST_PIO;                                  // [R11]
      end
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign prdata_out       = st_r.rdata;
  assign pready_out       = st_r.rdy;
  assign pslverr_out      = st_r.slverr;
  assign blk_ctl_stb_out  = st_r.bctl_stb;
  assign blk_ctl_data_out = st_r.bctl_data;
  assign blk_mode_out     = st_r.bmode;
  assign tst_ctl_stb_out  = st_r.tctl_stb;
  assign tst_ctl_data_out = st_r.tctl_data;
  assign tst_mode_out     = st_r.tmode;

  for (genvar c = 0; c < NCH; c++) begin : g_out
    assign irq_out[c]          = st_r.ch[c].irq;
    assign pin_out[c]          = st_r.ch[c].pout;
    assign pin_oe_out[c]       = st_r.ch[c].poe;
    assign tmr_out[c].ctl_stb  = st_r.ch[c].ctl_stb;
    assign tmr_out[c].ctl_data = st_r.ch[c].ctl_data;
    assign tmr_out[c].mode     = st_r.ch[c].mode;
    assign tmr_out[c].cc_a     = st_r.ch[c].cc_a;
    assign tmr_out[c].cc_b     = st_r.ch[c].cc_b;
    assign tmr_out[c].cmp_c    = st_r.ch[c].cmp_c;
    assign tmr_out[c].clk_on   = st_r.ch[c].clk_on;             // [R6]
    assign tmr_out[c].pin_lvl  = st_r.ch[c].s2;
  end

  // ----------------------------------------------------------------------
  // Assertions on channel zero and on the bus handshake
  // ----------------------------------------------------------------------
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!nrst_in);

  logic ch0_wr;
  assign ch0_wr = wr && (ch_idx == 4'h0);

  pio_hand_a: assert property (ch0_wr && ofs == OFS_PIO_EN && pwdata_in[PIN_LSB] // [R9]
    |=> st_r.ch[0].pio[0])
    else $error("pio enable did not hand pin to plain I/O");

  pio_return_a: assert property (ch0_wr && ofs == OFS_PIO_DIS && pwdata_in[PIN_LSB] // [R10]
    |=> !st_r.ch[0].pio[0])
    else $error("pio disable did not return pin to timer");

  pio_read_a: assert property (rd_done && ch_idx == 4'h0 && ofs == OFS_PIO_ST // [R11]
    |-> prdata_out[PIN_LSB +: NPIN] == st_r.ch[0].pio)
    else $error("pio status read wrong");

  pio_wins_a: assert property (st_r.ch[0].pio[0] && !st_r.ch[0].od[0] // [R17]
    |=> pin_oe_out[0][0] == $past(st_r.ch[0].oe[0]) && pin_out[0][0] == $past(st_r.ch[0].lvl[0]))
    else $error("plain I/O did not own the pin");

  level_set_a: assert property (ch0_wr && ofs == OFS_LVL_SET && pwdata_in[PIN_LSB] // [R18]
    |=> st_r.ch[0].lvl[0] ##1 (pin_out[0][0] || !st_r.ch[0].pio[0] || st_r.ch[0].od[0]))
    else $error("set level did not drive one");

  wave_no_load_a: assert property (st_r.ch[0].mode[MODE_WAVE_BIT] && !ch0_wr // [R3]
    && !st_r.ch[0].flags[IRQ_LDA] |=> !st_r.ch[0].flags[IRQ_LDA])
    else $error("capture load flag set in waveform mode");

  capt_no_cmp_a: assert property (!st_r.ch[0].mode[MODE_WAVE_BIT] && !ch0_wr // [R4]
    && !st_r.ch[0].flags[IRQ_CPA] |=> !st_r.ch[0].flags[IRQ_CPA])
    else $error("compare A flag set in capture mode");

  irq_masked_a: assert property (st_r.ch[0].imr == RST_IRQ |-> !irq_out[0]) // [R20]
    else $error("interrupt raised with empty mask");

  clk_gate_a: assert property (ch0_wr && ofs == OFS_CLK_EN && pwdata_in[PWR_BIT] // [R15]
    |=> tmr_out[0].clk_on)
    else $error("channel clock not enabled");

  reserved_zero_a: assert property (rd_done && paddr_in == 12'h00C // [R21]
    |-> prdata_out == RST_WORD)
    else $error("reserved offset read not zero");

  bus_ready_a: assert property (psel_in && penable_in && !pready_out
    |=> pready_out)
    else $error("pready late");

  cov_pio_write: cover property (ch0_wr && ofs == OFS_PIO_DIS);
  cov_irq_fire: cover property (irq_out[0]);
  cov_status_read: cover property (rd_done && ofs == OFS_STATUS);

endmodule // tpm_pin_irq_map

// file: logic/tpm_pkg.sv
package tpm_pkg;

  // ----------------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------------
  localparam int NCH  = 3;
  localparam int NPIN = 3;
  localparam int NIRQ = 11;
  localparam int AW   = 12;

  // ----------------------------------------------------------------------
  // Address map: channels repeat at a fixed stride, shared block above
  // ----------------------------------------------------------------------
  localparam logic [AW-1:0] CH_STRIDE     = 12'h100;
  localparam logic [7:0]    OFS_PIO_EN    = 8'h00;
  localparam logic [7:0]    OFS_PIO_DIS   = 8'h04;
  localparam logic [7:0]    OFS_PIO_ST    = 8'h08;
  localparam logic [7:0]    OFS_OE_EN     = 8'h10;
  localparam logic [7:0]    OFS_OE_DIS    = 8'h14;
  localparam logic [7:0]    OFS_OE_ST     = 8'h18;
  localparam logic [7:0]    OFS_LVL_SET   = 8'h30;
  localparam logic [7:0]    OFS_LVL_CLR   = 8'h34;
  localparam logic [7:0]    OFS_LVL_ST    = 8'h38;
  localparam logic [7:0]    OFS_PIN_ST    = 8'h3C;
  localparam logic [7:0]    OFS_OD_EN     = 8'h40;
  localparam logic [7:0]    OFS_OD_DIS    = 8'h44;
  localparam logic [7:0]    OFS_OD_ST     = 8'h48;
  localparam logic [7:0]    OFS_CLK_EN    = 8'h50;
  localparam logic [7:0]    OFS_CLK_DIS   = 8'h54;
  localparam logic [7:0]    OFS_PWR_ST    = 8'h58;
  localparam logic [7:0]    OFS_CTRL      = 8'h60;
  localparam logic [7:0]    OFS_MODE      = 8'h64;
  localparam logic [7:0]    OFS_STATUS    = 8'h70;
  localparam logic [7:0]    OFS_IRQ_EN    = 8'h74;
  localparam logic [7:0]    OFS_IRQ_DIS   = 8'h78;
  localparam logic [7:0]    OFS_IRQ_MASK  = 8'h7C;
  localparam logic [7:0]    OFS_CNT       = 8'h80;
  localparam logic [7:0]    OFS_CC_A      = 8'h84;
  localparam logic [7:0]    OFS_CC_B      = 8'h88;
  localparam logic [7:0]    OFS_CMP_C     = 8'h8C;
  localparam logic [AW-1:0] OFS_BLK_CTRL  = 12'h300;
  localparam logic [AW-1:0] OFS_BLK_MODE  = 12'h304;
  localparam logic [AW-1:0] OFS_TST_CTRL  = 12'h400;
  localparam logic [AW-1:0] OFS_TST_MODE  = 12'h404;

  // ----------------------------------------------------------------------
  // Fields and reset values
  // ----------------------------------------------------------------------
  localparam int          PIN_LSB       = 16;
  localparam int          MODE_WAVE_BIT = 15;
  localparam int          PWR_BIT       = 0;
  localparam logic [2:0]  RST_PIO       = 3'h7;
  localparam logic [2:0]  RST_PINCFG    = 3'h0;
  localparam logic [31:0] RST_WORD      = 32'h0000_0000;
  localparam logic [15:0] RST_HALF      = 16'h0000;
  localparam logic [10:0] RST_IRQ       = 11'h000;

  // Flag bit positions in channel status, enable, disable and mask.
  localparam int IRQ_OVF = 0;
  localparam int IRQ_LOVR = 1;
  localparam int IRQ_CPA = 2;
  localparam int IRQ_CPB = 3;
  localparam int IRQ_CPC = 4;
  localparam int IRQ_LDA = 5;
  localparam int IRQ_LDB = 6;
  localparam int IRQ_ETRG = 7;
  localparam int IRQ_CLKP = 8;
  localparam int IRQ_WAP = 9;
  localparam int IRQ_WBP = 10;

  localparam logic [10:0] AVAIL_BOTH = 11'h791;
  localparam logic [10:0] AVAIL_CAPT = 11'h062;
  localparam logic [10:0] AVAIL_WAVE = 11'h00C;

  // ----------------------------------------------------------------------
  // Carriers from and toward the counter logic of one channel
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  evt;
    logic [15:0] cnt;
    logic [2:0]  wave_lvl;
    logic [2:0]  wave_drv;
  } tpm_tmr_in_s;

  typedef struct packed {
    logic        ctl_stb;
    logic [31:0] ctl_data;
    logic [31:0] mode;
    logic [15:0] cc_a;
    logic [15:0] cc_b;
    logic [15:0] cmp_c;
    logic        clk_on;
    logic [2:0]  pin_lvl;
  } tpm_tmr_out_s;

endpackage

// file: test/tpm_pin_irq_map_tb_top.sv
`timescale 1ns/1ps

module tpm_pin_irq_map_tb_top;
  import tpm_pkg::*;
  logic                     ref_clk_in, nrst_in, psel, penable, pwrite, pready;
  logic [AW-1:0]            paddr;
  logic [31:0]              pwdata, prdata, q, blk_mode, tst_mode;
  tpm_tmr_in_s  [NCH-1:0]   tmr_in;
  tpm_tmr_out_s [NCH-1:0]   tmr_out;
  logic [NCH-1:0]           irq;
  logic [NCH-1:0][NPIN-1:0] pin_in, pin_out, pin_oe;
  int                       miscompares, n_checks, cyc;

  tpm_pin_irq_map u_tpm_pin_irq_map (.ref_clk_in(ref_clk_in), .nrst_in(nrst_in),
    .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
    .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(),
    .tmr_in(tmr_in), .tmr_out(tmr_out), .irq_out(irq), .blk_ctl_stb_out(),
    .blk_ctl_data_out(), .blk_mode_out(blk_mode), .tst_ctl_stb_out(), .tst_ctl_data_out(),
    .tst_mode_out(tst_mode), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_out(pin_oe));
  tpm_pin_model u_tpm_pin_model (.pin_out_in(pin_out), .pin_oe_in(pin_oe),
    .pin_lvl_out(pin_in));

  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic tally_and_finish();
    if (miscompares == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  function automatic logic [AW-1:0] ad(input logic [3:0] c, input logic [7:0] o);
    return {c, o};
  endfunction

  // The request is held until pready is seen high at a rising edge.
  task automatic apb(input logic w, input logic [AW-1:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk_in);
    penable <= 1'b1;
    do @(posedge ref_clk_in); while (pready !== 1'b1);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    // One idle edge, so the next call never drives psel twice in one step.
    @(posedge ref_clk_in);
  endtask

  task automatic wr(input logic [AW-1:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rc(input logic [AW-1:0] a, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0000_0000);
    chk(nm, q, e);
  endtask

  task automatic pulse(input int c, input logic [7:0] e);
    tmr_in[c].evt <= e;
    @(posedge ref_clk_in);
    tmr_in[c].evt <= 8'h00;
    repeat (2) @(posedge ref_clk_in);
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_reset();
    rc(ad(0, OFS_PIO_ST), 32'h0007_0000, "pio_st");
    rc(ad(1, OFS_OE_ST), 32'h0000_0000, "oe_st");
    rc(ad(2, OFS_OD_ST), 32'h0000_0000, "od_st");
    rc(ad(0, OFS_PWR_ST), 32'h0000_0000, "pwr_st");
    rc(ad(1, OFS_CC_B), 32'h0000_0000, "cc_b");
    rc(OFS_BLK_MODE, 32'h0000_0000, "blk_mode");
    rc(OFS_TST_MODE, 32'h0000_0000, "tst_mode");
    rc(ad(0, OFS_PIN_ST), 32'h0007_0000, "pin_st");
  endtask

  task automatic t_pio();
    wr(ad(1, OFS_PIO_DIS), 32'h0002_0000);
    rc(ad(1, OFS_PIO_ST), 32'h0005_0000, "pio_dis");
    rc(ad(0, OFS_PIO_ST), 32'h0007_0000, "pio_ch0");
    wr(ad(1, OFS_PIO_EN), 32'h0000_0000);
    rc(ad(1, OFS_PIO_ST), 32'h0005_0000, "pio_zero");
    wr(ad(1, OFS_PIO_EN), 32'h0002_0000);
    rc(ad(1, OFS_PIO_ST), 32'h0007_0000, "pio_en");
  endtask

  task automatic t_pins();
    wr(ad(0, OFS_OE_EN), 32'h0001_0000);
    wr(ad(0, OFS_LVL_SET), 32'h0001_0000);
    rc(ad(0, OFS_LVL_ST), 32'h0001_0000, "lvl_st");
    rc(ad(0, OFS_OE_ST), 32'h0001_0000, "oe_en");
    repeat (3) @(posedge ref_clk_in);
    chk("pin_oe", pin_oe[0], 3'b001);
    chk("pin_out_pio", pin_out[0][0], 1'b1);
    wr(ad(0, OFS_PIO_DIS), 32'h0001_0000);
    repeat (3) @(posedge ref_clk_in);
    chk("pin_out_tmr", pin_out[0][0], 1'b0);
    wr(ad(0, OFS_PIO_EN), 32'h0001_0000);
    wr(ad(0, OFS_LVL_CLR), 32'h0001_0000);
    repeat (8) @(posedge ref_clk_in);
    rc(ad(0, OFS_PIN_ST), 32'h0006_0000, "pin_low");
    wr(ad(0, OFS_OD_EN), 32'h0001_0000);
    rc(ad(0, OFS_OD_ST), 32'h0001_0000, "od_en");
    wr(ad(0, OFS_LVL_SET), 32'h0001_0000);
    repeat (3) @(posedge ref_clk_in);
    chk("od_release", pin_oe[0][0], 1'b0);
  endtask

  task automatic t_irq();
    wr(ad(0, OFS_IRQ_EN), 32'h0000_07FF);
    rc(ad(0, OFS_IRQ_MASK), 32'h0000_07FF, "mask_en");
    apb(1'b0, ad(0, OFS_STATUS), 32'h0000_0000);
    pulse(0, 8'hFF);
    chk("irq_on", irq[0], 1'b1);
    rc(ad(0, OFS_STATUS), 32'h0000_00F3, "st_capt");
    rc(ad(0, OFS_CC_A), 32'h0000_0ABC, "cc_a_load");
    rc(ad(0, OFS_CNT), 32'h0000_0ABC, "cnt");
    wr(ad(0, OFS_MODE), 32'h0000_8000);
    chk("mode_out", tmr_out[0].mode, 32'h0000_8000);
    pulse(0, 8'hFF);
    rc(ad(0, OFS_STATUS), 32'h0000_009D, "st_wave");
    wr(ad(0, OFS_IRQ_DIS), 32'h0000_07FF);
    rc(ad(0, OFS_IRQ_MASK), 32'h0000_0000, "mask_dis");
    pulse(0, 8'h01);
    chk("irq_masked", irq[0], 1'b0);
  endtask

  task automatic t_misc();
    wr(ad(0, OFS_CLK_EN), 32'h0000_0001);
    rc(ad(0, OFS_PWR_ST), 32'h0000_0001, "pwr_on");
    chk("clk_on0", tmr_out[0].clk_on, 1'b1);
    chk("clk_on1", tmr_out[1].clk_on, 1'b0);
    wr(ad(0, OFS_CLK_DIS), 32'h0000_0001);
    rc(ad(0, OFS_PWR_ST), 32'h0000_0000, "pwr_off");
    wr(ad(0, OFS_CMP_C), 32'h0000_5A5A);
    rc(ad(0, OFS_CMP_C), 32'h0000_5A5A, "cmp_c");
    chk("cmp_c_out", tmr_out[0].cmp_c, 32'h0000_5A5A);
    wr(OFS_TST_MODE, 32'h0000_005A);
    rc(OFS_TST_MODE, 32'h0000_005A, "tst_rd");
    chk("tst_out", tst_mode, 32'h0000_005A);
    wr(ad(0, 8'h0C), 32'hFFFF_FFFF);
    rc(ad(0, 8'h0C), 32'h0000_0000, "rsvd_0c");
    rc(12'h308, 32'h0000_0000, "rsvd_308");
    wr(OFS_BLK_MODE, 32'h0000_00A5);
    rc(OFS_BLK_MODE, 32'h0000_00A5, "blk_rd");
    chk("blk_out", blk_mode, 32'h0000_00A5);
  endtask

  // ----------------------------------------------------------------------
  // Clock, reset, watchdog and main sequence
  // ----------------------------------------------------------------------
  initial begin
    ref_clk_in = 1'b0;
    forever #2.5 ref_clk_in = ~ref_clk_in;
  end

  always @(posedge ref_clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      miscompares++;
      tally_and_finish();
    end
  end

  initial begin
    {miscompares, n_checks, cyc} = '0;
    {nrst_in, psel, penable, pwrite, paddr, pwdata} = '0;
    tmr_in = '0;
    tmr_in[0].wave_drv = 3'b001;
    tmr_in[0].cnt = 16'h0ABC;
    repeat (10) @(posedge ref_clk_in);
    nrst_in <= 1'b1;
    @(posedge ref_clk_in);
    t_reset();
    t_pio();
    t_pins();
    t_irq();
    t_misc();
    tally_and_finish();
  end
endmodule // tpm_pin_irq_map_tb_top

// file: test/tpm_pin_model.sv
`timescale 1ns/1ps

module tpm_pin_model
  import tpm_pkg::*;
(
  // Device side
  input  wire logic [NCH-1:0][NPIN-1:0] pin_out_in,
  input  wire logic [NCH-1:0][NPIN-1:0] pin_oe_in,
  // Board side
  output logic      [NCH-1:0][NPIN-1:0] pin_lvl_out
);
  // Board pull-ups hold every undriven line high, so a released pin never keeps its last value.
  assign pin_lvl_out = (pin_oe_in & pin_out_in) | ~pin_oe_in;
endmodule // tpm_pin_model
